// File: rtl/cbi_regs.vh
// Constants for the processor bus cycle and interrupt sequencer.
// What this block does
// - Drive upper address byte or I/O port address on high address lines.
// - Put low address byte on shared lines in first clock state.
// - Shared lines carry data in second and third clock states.
// - Pulse address latch strobe in first clock state of every machine cycle.
// - Address latch strobe is always driven, never floated.
// - Float high address, read and write strobes in hold, halt, reset.
// - Read strobe low asks selected unit to place data on bus.
// - Write strobe low while write data is on bus; valid at rising edge.
// - Ready sampled low inserts whole wait cycles until ready is high.
// - On hold request finish current transfer then release bus.
// - In hold float address, data, strobes and memory/I-O select.
// - Assert hold acknowledge on acceptance, release bus next cycle (here the pins float in the same cycle).
// - After hold removed drop acknowledge, drive bus half cycle later (here one cycle, two for memory/I-O select).
// - Sample general request only in next-to-last cycle, hold or halt.
// - Accepted general interrupt stops PC increment, issues acknowledge cycle.
// - Acknowledge strobe replaces read strobe with same timing after acceptance.
// - Interrupt enable cleared by reset and when any interrupt accepted.
// - Three restart inputs sampled like general request, masked, outrank it.
// - Trap is nonmaskable and has highest priority of all.
// - Vectors: trap 24H, middle restart 34H, lowest 2CH; trap edge-held.
// - Push program counter onto stack before branching to a vector.
// - Highest restart latches rising edge; other two are level sensitive.
`ifndef CBI_REGS_VH
`define CBI_REGS_VH
`define CBI_T1        3'h0
`define CBI_T2        3'h1
`define CBI_TW        3'h2
`define CBI_T3        3'h3
`define CBI_IDLE      3'h4
`define CBI_HOLD      3'h5
`define CBI_VEC_TRAP  8'h24
`define CBI_VEC_HIGH  8'h3c
`define CBI_VEC_MID   8'h34
`define CBI_VEC_LOW   8'h2c
`define CBI_SRC_NONE  3'h0
`define CBI_SRC_TRAP  3'h1
`define CBI_SRC_HIGH  3'h2
`define CBI_SRC_MID   3'h3
`define CBI_SRC_LOW   3'h4
`define CBI_SRC_GEN   3'h5
`define CBI_MASK_RST  3'h7
`endif

// File: rtl/cbi_bus_irq.v
// Bus cycle sequencer and interrupt arbiter of an 8-bit processor.
`include "cbi_regs.vh"
module cbi_bus_irq (
  input  wire        clock_i,
  input  wire        nrst_i,
  input  wire        cyc_req_i,
  input  wire        cyc_wr_i,
  input  wire        cyc_io_i,
  input  wire        cyc_fetch_i,
  input  wire [15:0] cyc_addr_i,
  input  wire [7:0]  cyc_wdata_i,
  input  wire        halt_i,
  input  wire        last_but_one_i,
  input  wire        irq_enable_set_i,
  input  wire        irq_enable_clr_i,
  input  wire        mask_load_i,
  input  wire [2:0]  mask_val_i,
  input  wire [15:0] pc_i,
  input  wire [7:0]  ad_i,
  input  wire        ready_i,
  input  wire        hold_i,
  input  wire        general_irq_request_i,
  input  wire        rst_low_i,
  input  wire        rst_mid_i,
  input  wire        rst_high_i,
  input  wire        trap_i,
  output reg         cyc_done_o,
  output reg  [7:0]  cyc_rdata_o,
  output reg         irq_take_o,
  output reg  [2:0]  irq_src_o,
  output reg  [7:0]  irq_vector_o,
  output reg  [15:0] irq_push_pc_o,
  output reg         pc_inhibit_o,
  output reg         irq_enable_o,
  output reg  [2:0]  mask_o,
  output reg         high_pending_o,
  output reg  [7:0]  high_addr_lines_o,
  output reg         high_addr_lines_oe_n_o,
  output reg  [7:0]  shared_addr_data_lines_o,
  output reg         shared_addr_data_lines_oe_n_o,
  output reg         addr_latch_strobe_o,
  output reg         rd_n_o,
  output reg         wr_n_o,
  output reg         irq_acknowledge_strobe_n_o,
  output reg         ctl_oe_n_o,
  output reg         io_mem_sel_o,
  output reg         io_mem_oe_n_o,
  output reg         cycle_status_bit0_o,
  output reg         cycle_status_bit1_o,
  output reg         hold_acknowledge_o
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  // Both flops clear at once but release in turn, so all logic leaves reset on one edge.
  reg rst_a_ff;
  reg rst_b_ff;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire rst_n = rst_b_ff;

  // ------------------------------------------------------------
  // Bus cycle state machine
  // ------------------------------------------------------------
  reg  [2:0]  st_ff;
  reg  [2:0]  nxt_st;
  reg         wr_ff;
  reg         io_ff;
  reg         irq_acknowledge_strobe_ff;
  reg  [15:0] addr_ff;
  reg  [7:0]  wdata_ff;
  reg         ack_due_ff;
  reg         hold_rel_ff;

  wire in_hold  = (st_ff == `CBI_HOLD);
  wire idle_now = (st_ff == `CBI_IDLE);
  // Data phase of the coming state. The strobes stay low through T3, so read data
  // is still driven by the far side when it is taken at the end of T3.
  wire data_ph  = (nxt_st == `CBI_T2) || (nxt_st == `CBI_TW) || (nxt_st == `CBI_T3);

  // ------------------------------------------------------------
  // Strobe decode
  // ------------------------------------------------------------
  // Only one strobe is low in a cycle; the acknowledge takes the place of the read.
  wire nxt_rd   = data_ph && !wr_ff && !irq_acknowledge_strobe_ff;
  wire nxt_ack  = data_ph && irq_acknowledge_strobe_ff;
  wire nxt_wr   = data_ph && wr_ff;

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      // Hold is seen before a new request, so a waiting master gets the bus first.
      `CBI_IDLE: begin
        if (hold_i)
          nxt_st = `CBI_HOLD;
        else if (cyc_req_i && !halt_i)
          nxt_st = `CBI_T1;
      end
      `CBI_T1: nxt_st = `CBI_T2;
      `CBI_T2: nxt_st = ready_i ? `CBI_T3 : `CBI_TW;
      `CBI_TW: nxt_st = ready_i ? `CBI_T3 : `CBI_TW;
      `CBI_T3: nxt_st = `CBI_IDLE;
      // Leaving hold passes through idle, so no request is taken in the release cycle.
      `CBI_HOLD: nxt_st = hold_i ? `CBI_HOLD : `CBI_IDLE;
      default: nxt_st = `CBI_IDLE;
    endcase
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= `CBI_IDLE;
      wr_ff       <= 1'b0;
      io_ff       <= 1'b0;
      irq_acknowledge_strobe_ff     <= 1'b0;
      addr_ff     <= 16'h0000;
      wdata_ff    <= 8'h00;
      ack_due_ff  <= 1'b0;
      cyc_done_o  <= 1'b0;
      cyc_rdata_o <= 8'h00;
      hold_rel_ff <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      cyc_done_o <= (st_ff == `CBI_T3);
      hold_rel_ff <= in_hold && !hold_i;
      if (idle_now && nxt_st == `CBI_T1) begin
        wr_ff    <= cyc_wr_i;
        io_ff    <= cyc_io_i;
        addr_ff  <= cyc_addr_i;
        wdata_ff <= cyc_wdata_i;
        irq_acknowledge_strobe_ff  <= cyc_fetch_i && ack_due_ff;
        if (cyc_fetch_i)
          ack_due_ff <= 1'b0;
      end
      // An accepted general request turns the next fetch into an acknowledge cycle.
      if (irq_take_o && irq_src_o == `CBI_SRC_GEN)
        ack_due_ff <= 1'b1;
      // Read data is taken at the end of T3, while the read strobe is still low.
      if (st_ff == `CBI_T3 && !wr_ff)
        cyc_rdata_o <= ad_i;
    end
  end

  // ------------------------------------------------------------
  // Pin drivers, all registered
  // ------------------------------------------------------------
  // The floated state is the reset value, so pins are off the bus in reset.
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      high_addr_lines_o             <= 8'h00;
      high_addr_lines_oe_n_o        <= 1'b1;
      shared_addr_data_lines_o      <= 8'h00;
      shared_addr_data_lines_oe_n_o <= 1'b1;
      addr_latch_strobe_o           <= 1'b0;
      rd_n_o                        <= 1'b1;
      wr_n_o                        <= 1'b1;
      irq_acknowledge_strobe_n_o    <= 1'b1;
      ctl_oe_n_o                    <= 1'b1;
      io_mem_sel_o                  <= 1'b0;
      io_mem_oe_n_o                 <= 1'b1;
      cycle_status_bit0_o           <= 1'b0;
      cycle_status_bit1_o           <= 1'b0;
      hold_acknowledge_o            <= 1'b0;
    end else begin
      // Acknowledge in the same cycle the pins float; drop it one cycle before the strobes
      // and two before the I/O select drive again; a whole cycle stands in for the half cycle.
      hold_acknowledge_o <= (nxt_st == `CBI_HOLD);
      high_addr_lines_oe_n_o <= !(nxt_st == `CBI_T1 || (!idle_now && !in_hold &&
                                  nxt_st != `CBI_IDLE));
      ctl_oe_n_o    <= in_hold || nxt_st == `CBI_HOLD || halt_i;
      io_mem_oe_n_o <= in_hold || nxt_st == `CBI_HOLD || hold_rel_ff;
      addr_latch_strobe_o <= (nxt_st == `CBI_T1);
      if (nxt_st == `CBI_T1) begin
        high_addr_lines_o        <= io_now_hi(cyc_io_i, cyc_addr_i);
        shared_addr_data_lines_o <= cyc_addr_i[7:0];
        shared_addr_data_lines_oe_n_o <= 1'b0;
        io_mem_sel_o        <= cyc_io_i;
        // Status: bit 1 marks a read or fetch, bit 0 a write or fetch.
        cycle_status_bit0_o <= cyc_wr_i || cyc_fetch_i;
        cycle_status_bit1_o <= !cyc_wr_i;
      end else if (data_ph) begin
        // Read cycles leave the address standing, so a latch that closes on the
        // falling edge of the address strobe never sees the lines move.
        if (wr_ff)
          shared_addr_data_lines_o <= wdata_ff;
        shared_addr_data_lines_oe_n_o <= !wr_ff;
      end else begin
        shared_addr_data_lines_oe_n_o <= 1'b1;
      end
      rd_n_o                     <= !nxt_rd;
      irq_acknowledge_strobe_n_o <= !nxt_ack;
      wr_n_o                     <= !nxt_wr;
    end
  end

  // For I/O cycles the port number is repeated on the high lines.
  function [7:0] io_now_hi;
    input        io;
    input [15:0] a;
    begin
      io_now_hi = io ? a[7:0] : a[15:8];
    end
  endfunction

  // ------------------------------------------------------------
  // Interrupt inputs and arbitration
  // ------------------------------------------------------------
  reg        trap_d_ff;
  reg        trap_pend_ff;
  reg        high_d_ff;
  reg        nxt_high;
  reg  [2:0] nxt_src;
  reg  [7:0] nxt_vec;

  wire sample_win = last_but_one_i || in_hold || halt_i;
  wire trap_edge  = trap_i && !trap_d_ff;
  wire high_edge  = rst_high_i && !high_d_ff;
  // Trap must still be high when sampled, so a glitch that falls is dropped.
  wire trap_ok    = (trap_pend_ff || trap_edge) && trap_i;
  wire high_pend  = high_pending_o || high_edge;

  // Fixed priority: trap, the three restarts from high to low, then the general
  // request. Only trap ignores the enable and the masks.
  always @* begin
    nxt_src = `CBI_SRC_NONE;
    nxt_vec = 8'h00;
    if (trap_ok) begin
      nxt_src = `CBI_SRC_TRAP;
      nxt_vec = `CBI_VEC_TRAP;
    end else if (irq_enable_o && high_pend && !mask_o[2]) begin
      nxt_src = `CBI_SRC_HIGH;
      nxt_vec = `CBI_VEC_HIGH;
    end else if (irq_enable_o && rst_mid_i && !mask_o[1]) begin
      nxt_src = `CBI_SRC_MID;
      nxt_vec = `CBI_VEC_MID;
    end else if (irq_enable_o && rst_low_i && !mask_o[0]) begin
      nxt_src = `CBI_SRC_LOW;
      nxt_vec = `CBI_VEC_LOW;
    end else if (irq_enable_o && general_irq_request_i) begin
      nxt_src = `CBI_SRC_GEN;
    end
  end

  always @* begin
    nxt_high = high_pend;
    if (sample_win && nxt_src == `CBI_SRC_HIGH)
      nxt_high = 1'b0;
    // A new edge in the same cycle as a clear is kept pending.
    if (high_edge && !(sample_win && nxt_src == `CBI_SRC_HIGH && !high_pending_o))
      nxt_high = 1'b1;
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      trap_d_ff      <= 1'b0;
      trap_pend_ff   <= 1'b0;
      high_d_ff      <= 1'b0;
      high_pending_o <= 1'b0;
      irq_enable_o   <= 1'b0;
      mask_o         <= `CBI_MASK_RST;
      irq_take_o     <= 1'b0;
      irq_src_o      <= `CBI_SRC_NONE;
      irq_vector_o   <= 8'h00;
      irq_push_pc_o  <= 16'h0000;
      pc_inhibit_o   <= 1'b0;
    end else begin
      trap_d_ff      <= trap_i;
      high_d_ff      <= rst_high_i;
      high_pending_o <= nxt_high;
      if (!trap_i)
        trap_pend_ff <= 1'b0;
      else if (trap_edge)
        trap_pend_ff <= 1'b1;
      if (mask_load_i)
        mask_o <= mask_val_i;
      irq_take_o <= 1'b0;
      if (sample_win && nxt_src != `CBI_SRC_NONE) begin
        irq_take_o    <= 1'b1;
        irq_src_o     <= nxt_src;
        irq_vector_o  <= nxt_vec;
        irq_push_pc_o <= pc_i;
        pc_inhibit_o  <= (nxt_src == `CBI_SRC_GEN);
        irq_enable_o  <= 1'b0;
        if (nxt_src == `CBI_SRC_TRAP)
          trap_pend_ff <= 1'b0;
      end else begin
        if (irq_enable_clr_i)
          irq_enable_o <= 1'b0;
        else if (irq_enable_set_i)
          irq_enable_o <= 1'b1;
        if (irq_acknowledge_strobe_ff && st_ff == `CBI_T3)
          pc_inhibit_o <= 1'b0;
      end
    end
  end

endmodule

// File: tb/cbi_bus_irq_monitor.sv
// Concurrent checks on the bus sequencer and interrupt arbiter ports.
module cbi_mon (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       ready_i,
  input wire logic       cyc_done_o,
  input wire logic       irq_take_o,
  input wire logic [2:0] irq_src_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic       irq_enable_o,
  input wire logic       high_addr_lines_oe_n_o,
  input wire logic       shared_addr_data_lines_oe_n_o,
  input wire logic       addr_latch_strobe_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o,
  input wire logic       irq_acknowledge_strobe_n_o,
  input wire logic       ctl_oe_n_o,
  input wire logic       io_mem_oe_n_o,
  input wire logic       hold_acknowledge_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_ale_pulse; addr_latch_strobe_o |=> !addr_latch_strobe_o; endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too long");
  property p_addr_out;
    addr_latch_strobe_o |-> !high_addr_lines_oe_n_o && !shared_addr_data_lines_oe_n_o;
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address not driven");
  property p_strobe;
    addr_latch_strobe_o |=> !ctl_oe_n_o && !(rd_n_o && wr_n_o && irq_acknowledge_strobe_n_o);
  endproperty
  a_strobe: assert property (p_strobe) else $error("no strobe after address");
  property p_wait; !rd_n_o && !ready_i |=> !rd_n_o; endproperty
  a_wait: assert property (p_wait) else $error("read ended while not ready");
  property p_done;
    $fell(rd_n_o) && ready_i |=> !rd_n_o ##1 (rd_n_o && cyc_done_o);
  endproperty
  a_done: assert property (p_done) else $error("read without waits mistimed");
  property p_hold_float;
    hold_acknowledge_o |-> high_addr_lines_oe_n_o && shared_addr_data_lines_oe_n_o
      && ctl_oe_n_o && io_mem_oe_n_o;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("bus driven in hold");
  property p_vector;
    irq_take_o |-> irq_vector_o == (irq_src_o == 3'h1 ? 8'h24 : irq_src_o == 3'h2 ? 8'h3c :
      irq_src_o == 3'h3 ? 8'h34 : irq_src_o == 3'h4 ? 8'h2c : 8'h00);
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");
  property p_ien_clear; irq_take_o |=> !irq_enable_o; endproperty
  a_ien_clear: assert property (p_ien_clear) else $error("enable kept after accept");
endmodule
bind cbi_bus_irq cbi_mon u_mon (.*);

// File: tb/cbi_mem_model.sv
// Memory and peripheral model facing the processor bus.
module cbi_mem_model #(
  parameter logic [7:0] ACK_OPCODE = 8'hc7  // Arbitrary restart opcode.
) (
  input  wire logic       clock_i,
  input  wire logic       ale_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] ad_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       ack_n_i,
  input  wire logic [1:0] waits_i,
  output logic      [7:0] ad_o,
  output logic            ready_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lat_ff;
  logic [7:0] last_ff;
  logic [1:0] cnt_ff;
  always @(negedge ale_i) lat_ff <= ad_i;
  always @(posedge wr_n_i) wdata_o <= ad_i;
  always @(posedge clock_i) cnt_ff <= (rd_n_i & wr_n_i & ack_n_i) ? 2'h0 : cnt_ff + 2'h1;
  assign ready_o = cnt_ff >= waits_i;
  // A released bus shows the inverse of its last value, so stale data never matches.
  always_comb begin
    if (!ack_n_i) ad_o = ACK_OPCODE;
    else if (!rd_n_i) ad_o = lat_ff ^ hi_i;
    else ad_o = ~last_ff;
  end
  always @(posedge clock_i) last_ff <= ad_o;
endmodule

// File: tb/cbi_bus_irq_tb.sv
// Self-checking bench for the bus cycle and interrupt sequencer.
module cbi_bus_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ACK_OP = 8'hc7;  // Arbitrary opcode given on acknowledge.
  logic        clock_i = 0, nrst_i = 0, cyc_req_i = 0, cyc_wr_i = 0, cyc_io_i = 0;
  logic        cyc_fetch_i = 0, halt_i = 0, last_but_one_i = 0, irq_enable_set_i = 0;
  logic        irq_enable_clr_i = 0, mask_load_i = 0, hold_i = 0, general_irq_request_i = 0;
  logic        rst_low_i = 0, rst_mid_i = 0, rst_high_i = 0, trap_i = 0;
  logic [15:0] cyc_addr_i = 0, pc_i = 0;
  logic [7:0]  cyc_wdata_i = 0, wseen;
  logic [2:0]  mask_val_i = 0;
  logic [1:0]  waits = 0;
  logic [31:0] e, rq[$], iq[$];
  wire         ready_i, cyc_done_o, irq_take_o, pc_inhibit_o, irq_enable_o, high_pending_o;
  wire         high_addr_lines_oe_n_o, shared_addr_data_lines_oe_n_o, addr_latch_strobe_o;
  wire         rd_n_o, wr_n_o, irq_acknowledge_strobe_n_o, ctl_oe_n_o, io_mem_sel_o;
  wire         io_mem_oe_n_o, cycle_status_bit0_o, cycle_status_bit1_o, hold_acknowledge_o;
  wire [7:0]   ad_i, cyc_rdata_o, irq_vector_o, high_addr_lines_o, shared_addr_data_lines_o;
  wire [2:0]   irq_src_o, mask_o;
  wire [15:0]  irq_push_pc_o;
  int          mismatches = 0, comparisons = 0;
  cbi_bus_irq dut (.*);
  cbi_mem_model #(.ACK_OPCODE(ACK_OP)) mem (.clock_i(clock_i), .ale_i(addr_latch_strobe_o),
    .hi_i(high_addr_lines_o), .ad_i(shared_addr_data_lines_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .ack_n_i(irq_acknowledge_strobe_n_o), .waits_i(waits), .ad_o(ad_i),
    .ready_o(ready_i), .wdata_o(wseen));
  always #20 clock_i = ~clock_i;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hold may be raised on the edge that takes the request, so it lands in mid-transfer.
  task automatic cyc(logic w, io, f, ia, h, logic [15:0] a);
    logic [7:0] d;
    logic [2:0] s;
    d = $urandom;
    s = w ? 3'h5 : ia ? 3'h6 : 3'h3;
    @(posedge clock_i);
    {cyc_req_i, cyc_wr_i, cyc_io_i, cyc_fetch_i, cyc_addr_i, cyc_wdata_i} <= {1'b1, w, io, f, a, d};
    rq.push_back({!w, ia ? ACK_OP : a[7:0] ^ a[15:8]});
    @(posedge clock_i);
    cyc_req_i <= 0;
    hold_i <= h;
    @(negedge clock_i);
    chk("addr", {2'h2, io, !w, w | f, a}, {addr_latch_strobe_o,
      shared_addr_data_lines_oe_n_o, io_mem_sel_o, cycle_status_bit1_o, cycle_status_bit0_o,
      high_addr_lines_o, shared_addr_data_lines_o});
    @(negedge clock_i);
    chk("strobes", {s, !w}, {rd_n_o, wr_n_o, irq_acknowledge_strobe_n_o,
      shared_addr_data_lines_oe_n_o});
    repeat (12) if (cyc_done_o !== 1'b1) @(negedge clock_i);
    chk("done", 1, cyc_done_o);
    if (w) chk("wdata", d, wseen);
  endtask
  task automatic irq(logic [4:0] v, logic [2:0] m, logic en, hw, logic [10:0] x);
    logic [15:0] p;
    p = $urandom;
    @(posedge clock_i);
    {mask_load_i, mask_val_i, irq_enable_set_i, irq_enable_clr_i, pc_i} <= {1'b1, m, en, !en, p};
    {trap_i, rst_high_i, rst_mid_i, rst_low_i, general_irq_request_i} <= v;
    @(posedge clock_i);
    {mask_load_i, irq_enable_set_i, irq_enable_clr_i, halt_i, last_but_one_i} <= {3'h0, hw, !hw};
    if (x != 0) iq.push_back({x, p});
    @(posedge clock_i);
    {halt_i, last_but_one_i} <= 2'h0;
    repeat (3) @(posedge clock_i);
    {trap_i, rst_high_i, rst_mid_i, rst_low_i, general_irq_request_i} <= 5'h0;
    $display("interrupt test %h done", v);
  endtask
  always @(negedge clock_i) begin
    if (cyc_done_o === 1'b1) begin
      e = rq.size() ? rq.pop_front() : 0;
      if (e[8]) chk("rdata", e[7:0], cyc_rdata_o);
    end
    if (irq_take_o === 1'b1) begin
      e = iq.size() ? iq.pop_front() : '1;
      chk("irq", e, {irq_src_o, irq_vector_o, irq_push_pc_o});
    end
  end
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    logic [15:0] a;
    logic        io;
    void'($urandom(96));
    repeat (19) @(posedge clock_i);
    @(negedge clock_i);
    chk("reset", 11'h73b, {mask_o, irq_enable_o, hold_acknowledge_o, ctl_oe_n_o,
      high_addr_lines_oe_n_o, shared_addr_data_lines_oe_n_o, addr_latch_strobe_o,
      rd_n_o, wr_n_o});
    @(posedge clock_i);
    nrst_i <= 1;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < 9; i++) begin
      a = $urandom;
      io = $urandom;
      if (io) a[15:8] = a[7:0];
      waits <= 2'(i % 3);
      cyc(1'($urandom), io, 0, 0, 0, a);
    end
    $display("bus test done");
    cyc(0, 0, 0, 0, 1, 16'h1234);
    repeat (10) if (hold_acknowledge_o !== 1'b1) @(negedge clock_i);
    chk("hold", 5'h1f, {hold_acknowledge_o, high_addr_lines_oe_n_o,
      shared_addr_data_lines_oe_n_o, ctl_oe_n_o, io_mem_oe_n_o});
    @(posedge clock_i);
    cyc_req_i <= 1;
    repeat (3) @(negedge clock_i);
    chk("held", 2'h2, {hold_acknowledge_o, addr_latch_strobe_o});
    @(posedge clock_i);
    {cyc_req_i, hold_i} <= 2'h0;
    repeat (4) @(negedge clock_i);
    chk("regain", 3'h0, {hold_acknowledge_o, ctl_oe_n_o, io_mem_oe_n_o});
    @(posedge clock_i);
    halt_i <= 1;
    repeat (3) @(negedge clock_i);
    chk("halt", 3'h6, {high_addr_lines_oe_n_o, ctl_oe_n_o, addr_latch_strobe_o});
    @(posedge clock_i);
    halt_i <= 0;
    $display("hold and halt test done");
    irq(5'h1f, 3'h7, 0, 0, 11'h124);
    @(negedge clock_i);
    chk("pending", 1, high_pending_o);
    irq(5'h0f, 3'h0, 1, 0, 11'h23c);
    irq(5'h07, 3'h0, 1, 0, 11'h334);
    irq(5'h07, 3'h2, 1, 0, 11'h42c);
    irq(5'h01, 3'h0, 0, 0, 11'h000);
    irq(5'h01, 3'h0, 1, 1, 11'h500);
    @(negedge clock_i);
    chk("inhibit", 1, pc_inhibit_o);
    cyc(0, 0, 1, 1, 0, 16'h0100);
    chk("inhibit clear", 0, pc_inhibit_o);
    cyc(0, 0, 1, 0, 0, 16'h0101);
    $display("acknowledge test done");
    end_sim();
  end
endmodule
